// [logic/pcx_params.svh]
`ifndef PCX_PARAMS_SVH
`define PCX_PARAMS_SVH

// Configuration offsets
`define PCX_OFF_DEV_CTL2   12'h0c8
`define PCX_OFF_LNK_CTL2   12'h0d0
`define PCX_OFF_AER_HDR    12'h100
`define PCX_OFF_UNC_STAT   12'h104
`define PCX_OFF_UNC_MASK   12'h108
`define PCX_OFF_UNC_SEV    12'h10c
`define PCX_OFF_COR_STAT   12'h110
`define PCX_OFF_COR_MASK   12'h114
`define PCX_OFF_AER_CTL    12'h118
`define PCX_OFF_HLOG0      12'h11c
`define PCX_OFF_HLOG1      12'h120
`define PCX_OFF_HLOG2      12'h124
`define PCX_OFF_HLOG3      12'h128
`define PCX_OFF_SN_CAP     12'h140
`define PCX_OFF_HINT_CAP   12'h1a0
`define PCX_OFF_LAT_CAP    12'h1c0
`define PCX_OFF_CAP_END    12'h000

// Field layouts and reset values
`define PCX_AER_CAP_ID     16'h0001
`define PCX_AER_VER_RST    4'h2
`define PCX_DEV_CTL2_RST   16'h0000
`define PCX_DEV_CTL2_WMASK 16'h031f
`define PCX_LNK_CTL2_RST   16'h0001
`define PCX_LNK_CTL2_WMASK 16'h1f9f
`define PCX_DC2_CTO_DIS    4
`define PCX_DC2_IDO_REQ    8
`define PCX_DC2_IDO_CPL    9
`define PCX_LC2_ENTER_COMP 4
`define PCX_LC2_MOD_COMP   10
`define PCX_LC2_COMP_SKP   11
`define PCX_LC2_COMP_DEEMP 12
`define PCX_UNC_IMPL       32'h001ff010
`define PCX_UNC_SEV_RST    32'h00462031
`define PCX_UNC_BIT_CTO    14
`define PCX_COR_IMPL       32'h000031c1
`define PCX_COR_MASK_RST   32'h00002000
`define PCX_AER_CTL_WMASK  32'h00000140
`define PCX_AER_CTL_ONES   32'h000000a0

// Timing
`define PCX_CLK_NS         25
`define PCX_US_NS          1000
`define PCX_TICK_CYC       (`PCX_US_NS / `PCX_CLK_NS)
`define PCX_CTO_US_DEF     24000
`define PCX_CTO_US_A1      50
`define PCX_CTO_US_A2      1500
`define PCX_CTO_US_B1      24000
`define PCX_CTO_US_B2      97000
`define PCX_CTO_US_C1      390000
`define PCX_CTO_US_C2      1500000
`define PCX_CTO_US_D1      4000000
`define PCX_CTO_US_D2      6000000

`endif

// [logic/pcx_pkg.sv]
package pcx_pkg;
  typedef enum logic [3:0] {
    PCX_CTO_DEF = 4'h0,
    PCX_CTO_A1  = 4'h1,
    PCX_CTO_A2  = 4'h2,
    PCX_CTO_B1  = 4'h5,
    PCX_CTO_B2  = 4'h6,
    PCX_CTO_C1  = 4'h9,
    PCX_CTO_C2  = 4'ha,
    PCX_CTO_D1  = 4'hd,
    PCX_CTO_D2  = 4'he
  } pcx_cto_code_t;

  typedef enum logic {
    PCX_TMR_IDLE = 1'b0,
    PCX_TMR_RUN  = 1'b1
  } pcx_tmr_state_t;

  typedef logic [22:0] pcx_us_t;
endpackage : pcx_pkg

// [logic/pcx_cto_if.sv]
interface pcx_cto_if;
  logic       tick;
  logic       dis;
  logic       issue;
  logic       done;
  logic [3:0] code;
  logic       expire;

  modport ctl (output tick, dis, issue, done, code, input expire);
  modport tmr (input tick, dis, issue, done, code, output expire);
endinterface : pcx_cto_if

// [logic/pcx_cto_timer.sv]
`include "pcx_params.svh"

module pcx_cto_timer (
  input wire logic mclk,
  input wire logic nrst,
  pcx_cto_if.tmr   bus
);
  pcx_pkg::pcx_tmr_state_t state;
  pcx_pkg::pcx_us_t        cnt;
  pcx_pkg::pcx_us_t        target;

  function automatic pcx_pkg::pcx_us_t cto_us(input logic [3:0] c);
    case (c)
      pcx_pkg::PCX_CTO_A1: cto_us = 23'(`PCX_CTO_US_A1);
      pcx_pkg::PCX_CTO_A2: cto_us = 23'(`PCX_CTO_US_A2);
      pcx_pkg::PCX_CTO_B1: cto_us = 23'(`PCX_CTO_US_B1);
      pcx_pkg::PCX_CTO_B2: cto_us = 23'(`PCX_CTO_US_B2);
      pcx_pkg::PCX_CTO_C1: cto_us = 23'(`PCX_CTO_US_C1);
      pcx_pkg::PCX_CTO_C2: cto_us = 23'(`PCX_CTO_US_C2);
      pcx_pkg::PCX_CTO_D1: cto_us = 23'(`PCX_CTO_US_D1);
      pcx_pkg::PCX_CTO_D2: cto_us = 23'(`PCX_CTO_US_D2);
      default:             cto_us = 23'(`PCX_CTO_US_DEF);
    endcase
  endfunction : cto_us

  assign target = cto_us(bus.code);

  // One outstanding request, timed in microsecond ticks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state      <= pcx_pkg::PCX_TMR_IDLE;
      cnt        <= '0;
      bus.expire <= 1'b0;
    end else begin
      bus.expire <= 1'b0;
      case (state)
        pcx_pkg::PCX_TMR_IDLE: begin
          if (bus.issue) begin
            state <= pcx_pkg::PCX_TMR_RUN;
            cnt   <= '0;
          end
        end
        pcx_pkg::PCX_TMR_RUN: begin
          if (bus.done) begin
            state <= pcx_pkg::PCX_TMR_IDLE;
          end else if (bus.dis) begin
            cnt <= '0;
          end else if (bus.tick) begin
            if (cnt == target - 23'h1) begin
              bus.expire <= 1'b1;
              state      <= pcx_pkg::PCX_TMR_IDLE;
            end else begin
              cnt <= cnt + 23'h1;
            end
          end
        end
        default: state <= pcx_pkg::PCX_TMR_IDLE;
      endcase
    end
  end

  // Age and bounds seen by the checks only
  pcx_pkg::pcx_us_t age;
  logic             clean;
  logic [3:0]       code_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      age    <= '0;
      clean  <= 1'b0;
      code_q <= 4'h0;
    end else if (state == pcx_pkg::PCX_TMR_IDLE && bus.issue) begin
      age    <= '0;
      clean  <= !bus.dis;
      code_q <= bus.code;
    end else if (state == pcx_pkg::PCX_TMR_RUN) begin
      if (bus.tick) begin
        age <= age + 23'h1;
      end
      if (bus.dis || bus.code != code_q) begin
        clean <= 1'b0;
      end
    end
  end

  function automatic pcx_pkg::pcx_us_t lo_us(input logic [3:0] c);
    case (c)
      pcx_pkg::PCX_CTO_A1: lo_us = 23'd10;
      pcx_pkg::PCX_CTO_A2: lo_us = 23'd1000;
      pcx_pkg::PCX_CTO_B2: lo_us = 23'd65000;
      pcx_pkg::PCX_CTO_C1: lo_us = 23'd260000;
      pcx_pkg::PCX_CTO_C2: lo_us = 23'd1000000;
      pcx_pkg::PCX_CTO_D1: lo_us = 23'd1000000;
      pcx_pkg::PCX_CTO_D2: lo_us = 23'd4000000;
      default:             lo_us = 23'd16000;
    endcase
  endfunction : lo_us

  function automatic pcx_pkg::pcx_us_t hi_us(input logic [3:0] c);
    case (c)
      pcx_pkg::PCX_CTO_A1: hi_us = 23'd100;
      pcx_pkg::PCX_CTO_A2: hi_us = 23'd2000;
      pcx_pkg::PCX_CTO_B2: hi_us = 23'd130000;
      pcx_pkg::PCX_CTO_C1: hi_us = 23'd520000;
      pcx_pkg::PCX_CTO_C2: hi_us = 23'd2000000;
      pcx_pkg::PCX_CTO_D1: hi_us = 23'd8000000;
      pcx_pkg::PCX_CTO_D2: hi_us = 23'd8000000;
      default:             hi_us = 23'd32000;
    endcase
  endfunction : hi_us

  a_cto_window: assert property (@(posedge mclk) disable iff (!nrst)
    bus.expire && clean |-> age >= lo_us(code_q) && age <= hi_us(code_q))
    else $error("completion timeout outside its range");

  a_cto_disabled: assert property (@(posedge mclk) disable iff (!nrst)
    bus.dis |=> !bus.expire)
    else $error("timeout fired while disabled");
endmodule : pcx_cto_timer

// [logic/pcx_cfg_regs.sv]
// Notes on behaviour
// - Default timeout code gives 16 to 32 ms
// - Codes 0001b, 0010b give short timeout ranges
// - Codes 0101b, 0110b give middle timeout ranges
// - Codes 1001b, 1010b give long timeout ranges
// - Codes 1101b, 1110b time out within 1-8 s
// - Disable bit stops completion timeout detection
// - Request ordering attribute only when enabled
// - Completion ordering attribute only when enabled
// - Device control bits 7:5 read zero
// - Target speed sticky, resets to 2.5 Gb/s
// - Enter compliance sticky, cleared by fundamental reset
// - Link control bits 6:5 hardwired zero
// - Modified compliance pattern selected by bit 10
// - Skip sets between compliance patterns, bit 11
// - Compliance de-emphasis ignored at 2.5 GT/s
// - Link status two: de-emphasis, rest zero
// - Extended configuration address field decode
// - Capability list starts at 0x100
// - Next pointers skip disabled capabilities
// - Error header: id, loaded version, pointer
// - Error flags set by events, write-one clear
`include "pcx_params.svh"

module pcx_cfg_regs #(
  parameter int NTAG     = 4,
  parameter int TICK_CYC = `PCX_TICK_CYC
) (
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic            hot_rst,
  input  wire logic            cfg_req,
  input  wire logic            cfg_wr,
  input  wire logic [31:0]     cfg_addr,
  input  wire logic [3:0]      cfg_be,
  input  wire logic [31:0]     cfg_wdata,
  input  wire logic [7:0]      own_bus,
  input  wire logic [4:0]      own_dev,
  input  wire logic [2:0]      own_fn,
  output logic                 cfg_ack,
  output logic                 cfg_ur,
  output logic [31:0]          cfg_rdata,
  input  wire logic            nvm_load,
  input  wire logic [3:0]      nvm_aer_ver,
  input  wire logic            sn_cap_en,
  input  wire logic            hint_cap_en,
  input  wire logic            lat_cap_en,
  input  wire logic [NTAG-1:0] req_issue,
  input  wire logic [NTAG-1:0] cpl_done,
  output logic                 cto_expired,
  input  wire logic            link_5gt,
  input  wire logic            cur_deemph,
  input  wire logic [31:0]     unc_err_set,
  input  wire logic [31:0]     cor_err_set,
  input  wire logic [127:0]    err_hdr,
  output logic                 ido_req_en,
  output logic                 ido_cpl_en,
  output logic [3:0]           tgt_speed,
  output logic                 enter_compliance,
  output logic                 mod_compliance,
  output logic                 compliance_skp,
  output logic                 compliance_deemph
);
  logic [15:0]  dev_ctl_two;
  logic [15:0]  lnk_ctl_two;
  logic [3:0]   aer_ver;
  logic [31:0]  unc_flags;
  logic [31:0]  unc_mask;
  logic [31:0]  unc_sev;
  logic [31:0]  cor_flags;
  logic [31:0]  cor_mask;
  logic [31:0]  aer_ctl;
  logic [4:0]   first_ptr;
  logic [26:0]  aer_ctl_hi;
  logic [127:0] hdr_log;
  logic [11:0]  off;
  logic         hit;
  logic         wr;
  logic [31:0]  bmask;
  logic [11:0]  next_ptr;
  logic [15:0]  lnk_stat_two;
  logic [31:0]  next_rdata;
  logic [NTAG-1:0] cto_hit;
  logic         cto_any;
  logic [31:0]  unc_set;
  logic [31:0]  unc_clr;
  logic [31:0]  unc_new;
  logic [31:0]  cor_clr;
  logic [4:0]   first_bit;
  logic [$clog2(TICK_CYC+1)-1:0] div;
  logic         tick;

  // Address decode and byte lanes
  assign hit = cfg_addr[31:28] == 4'h0 && cfg_addr[1:0] == 2'b00 &&
               cfg_addr[27:20] == own_bus && cfg_addr[19:15] == own_dev &&
               cfg_addr[14:12] == own_fn;
  assign off   = {cfg_addr[11:2], 2'b00};
  assign wr    = cfg_req && cfg_wr && hit;
  assign bmask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                  {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // Device control two, cleared by either reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dev_ctl_two <= `PCX_DEV_CTL2_RST;
    end else if (hot_rst) begin
      dev_ctl_two <= `PCX_DEV_CTL2_RST;
    end else if (wr && off == `PCX_OFF_DEV_CTL2) begin
      dev_ctl_two <= 16'(merge({16'h0, dev_ctl_two}, cfg_wdata,
                               bmask & {16'h0, `PCX_DEV_CTL2_WMASK}));
    end
  end

  // Link control two, sticky across hot reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lnk_ctl_two <= `PCX_LNK_CTL2_RST;
    end else if (wr && off == `PCX_OFF_LNK_CTL2) begin
      lnk_ctl_two <= 16'(merge({16'h0, lnk_ctl_two}, cfg_wdata,
                               bmask & {16'h0, `PCX_LNK_CTL2_WMASK}));
    end
  end

  // Link side controls
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ido_req_en        <= 1'b0;
      ido_cpl_en        <= 1'b0;
      tgt_speed         <= 4'h1;
      enter_compliance  <= 1'b0;
      mod_compliance    <= 1'b0;
      compliance_skp    <= 1'b0;
      compliance_deemph <= 1'b0;
    end else begin
      ido_req_en        <= dev_ctl_two[`PCX_DC2_IDO_REQ];
      ido_cpl_en        <= dev_ctl_two[`PCX_DC2_IDO_CPL];
      tgt_speed         <= lnk_ctl_two[3:0];
      enter_compliance  <= lnk_ctl_two[`PCX_LC2_ENTER_COMP];
      mod_compliance    <= lnk_ctl_two[`PCX_LC2_MOD_COMP];
      compliance_skp    <= lnk_ctl_two[`PCX_LC2_COMP_SKP];
      compliance_deemph <= link_5gt &&
                           lnk_ctl_two[`PCX_LC2_COMP_DEEMP];
    end
  end

  // Capability version, reloaded from configuration memory
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aer_ver <= `PCX_AER_VER_RST;
    end else if (nvm_load) begin
      aer_ver <= nvm_aer_ver;
    end
  end

  always_comb begin
    if (sn_cap_en) begin
      next_ptr = `PCX_OFF_SN_CAP;
    end else if (hint_cap_en) begin
      next_ptr = `PCX_OFF_HINT_CAP;
    end else if (lat_cap_en) begin
      next_ptr = `PCX_OFF_LAT_CAP;
    end else begin
      next_ptr = `PCX_OFF_CAP_END;
    end
  end

  assign lnk_stat_two = {15'h0, link_5gt && cur_deemph};

  // Microsecond tick for the timeout counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div  <= '0;
      tick <= 1'b0;
    end else if (div == $bits(div)'(TICK_CYC - 1)) begin
      div  <= '0;
      tick <= 1'b1;
    end else begin
      div  <= div + 1'b1;
      tick <= 1'b0;
    end
  end

  // One timeout counter per outstanding request tag
  for (genvar g = 0; g < NTAG; g++) begin : g_cto
    pcx_cto_if cto ();
    assign cto.tick  = tick;
    assign cto.dis   = dev_ctl_two[`PCX_DC2_CTO_DIS];
    assign cto.issue = req_issue[g];
    assign cto.done  = cpl_done[g];
    assign cto.code  = dev_ctl_two[3:0];
    assign cto_hit[g] = cto.expire;
    pcx_cto_timer u_tmr (
      .mclk (mclk),
      .nrst (nrst),
      .bus  (cto.tmr)
    );
  end

  assign cto_any = |cto_hit;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cto_expired <= 1'b0;
    end else begin
      cto_expired <= cto_any;
    end
  end

  // Error flags: a new event wins over a write-one clear
  assign unc_set = (unc_err_set | (32'(cto_any) << `PCX_UNC_BIT_CTO))
                   & `PCX_UNC_IMPL;
  assign unc_clr = (wr && off == `PCX_OFF_UNC_STAT) ?
                   (cfg_wdata & bmask) : 32'h0;
  assign cor_clr = (wr && off == `PCX_OFF_COR_STAT) ?
                   (cfg_wdata & bmask) : 32'h0;
  assign unc_new = unc_set & ~unc_flags;

  always_comb begin
    first_bit = 5'h0;
    for (int i = 31; i >= 0; i--) begin
      if (unc_new[i]) begin
        first_bit = 5'(i);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unc_flags <= 32'h0;
      cor_flags <= 32'h0;
    end else begin
      unc_flags <= (unc_flags & ~unc_clr) | unc_set;
      cor_flags <= (cor_flags & ~cor_clr) |
                   (cor_err_set & `PCX_COR_IMPL);
    end
  end

  // First error pointer and header log caught on the first event
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hdr_log       <= 128'h0;
      first_ptr     <= 5'h0;
    end else if (|unc_new && (unc_flags & ~unc_clr) == 32'h0) begin
      hdr_log       <= err_hdr;
      first_ptr     <= first_bit;
    end
  end

  assign aer_ctl = {aer_ctl_hi, first_ptr};

  // Mask, severity and error control
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      unc_mask      <= 32'h0;
      unc_sev       <= `PCX_UNC_SEV_RST;
      cor_mask      <= `PCX_COR_MASK_RST;
      aer_ctl_hi    <= 27'(`PCX_AER_CTL_ONES >> 5);
    end else if (wr) begin
      case (off)
        `PCX_OFF_UNC_MASK:
          unc_mask <= merge(unc_mask, cfg_wdata, bmask & `PCX_UNC_IMPL);
        `PCX_OFF_UNC_SEV:
          unc_sev <= merge(unc_sev, cfg_wdata, bmask & `PCX_UNC_IMPL);
        `PCX_OFF_COR_MASK:
          cor_mask <= merge(cor_mask, cfg_wdata, bmask & `PCX_COR_IMPL);
        `PCX_OFF_AER_CTL:
          aer_ctl_hi <= 27'(merge(aer_ctl, cfg_wdata,
                                  bmask & `PCX_AER_CTL_WMASK) >> 5);
        default: ;
      endcase
    end
  end

  // Read data
  always_comb begin
    case (off)
      `PCX_OFF_DEV_CTL2: next_rdata = {16'h0, dev_ctl_two};
      `PCX_OFF_LNK_CTL2: next_rdata = {lnk_stat_two, lnk_ctl_two};
      `PCX_OFF_AER_HDR:  next_rdata = {next_ptr, aer_ver,
                                       `PCX_AER_CAP_ID};
      `PCX_OFF_UNC_STAT: next_rdata = unc_flags;
      `PCX_OFF_UNC_MASK: next_rdata = unc_mask;
      `PCX_OFF_UNC_SEV:  next_rdata = unc_sev;
      `PCX_OFF_COR_STAT: next_rdata = cor_flags;
      `PCX_OFF_COR_MASK: next_rdata = cor_mask;
      `PCX_OFF_AER_CTL:  next_rdata = aer_ctl;
      `PCX_OFF_HLOG0:    next_rdata = hdr_log[31:0];
      `PCX_OFF_HLOG1:    next_rdata = hdr_log[63:32];
      `PCX_OFF_HLOG2:    next_rdata = hdr_log[95:64];
      `PCX_OFF_HLOG3:    next_rdata = hdr_log[127:96];
      default:           next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_ack   <= 1'b0;
      cfg_ur    <= 1'b0;
      cfg_rdata <= 32'h0;
    end else begin
      cfg_ack   <= cfg_req;
      cfg_ur    <= cfg_req && !hit;
      cfg_rdata <= (cfg_req && !cfg_wr && hit) ? next_rdata : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_read_at(logic [11:0] o);
    cfg_req && !cfg_wr && hit && off == o;
  endsequence

  sequence s_clear_unc(int b);
    wr && off == `PCX_OFF_UNC_STAT && cfg_wdata[b] && cfg_be[b/8];
  endsequence

  a_devctl_ro_bits: assert property (
    s_read_at(`PCX_OFF_DEV_CTL2) |=> cfg_ack && cfg_rdata[7:5] == 3'h0)
    else $error("device control bits 7:5 not zero");

  a_lnk_hardwired: assert property (
    s_read_at(`PCX_OFF_LNK_CTL2) |=> cfg_rdata[6:5] == 2'h0)
    else $error("link control bits 6:5 not zero");

  a_lnk_stat_zero: assert property (
    s_read_at(`PCX_OFF_LNK_CTL2) |=> cfg_rdata[31:17] == 15'h0 &&
      (cfg_rdata[16] == ($past(link_5gt) && $past(cur_deemph))))
    else $error("link status two read wrong");

  a_cap_header: assert property (
    s_read_at(`PCX_OFF_AER_HDR) |=> cfg_rdata[15:0] == 16'h0001 &&
      cfg_rdata[19:16] == $past(aer_ver) &&
      cfg_rdata[31:20] == ($past(sn_cap_en) ? 12'h140 :
                           $past(hint_cap_en) ? 12'h1a0 :
                           $past(lat_cap_en) ? 12'h1c0 : 12'h000))
    else $error("error capability header wrong");

  a_flag_clear: assert property (
    s_clear_unc(12) ##0 !unc_set[12] |=> !unc_flags[12])
    else $error("write one did not clear the flag");

  a_flag_set_wins: assert property (
    unc_err_set[18] |=> unc_flags[18] ##1
      (unc_flags[18] || $past(unc_clr[18])))
    else $error("error event lost");

  a_flag_low_zero: assert property (
    s_read_at(`PCX_OFF_UNC_STAT) |=> cfg_rdata[3:0] == 4'h0)
    else $error("reserved error flags not zero");

  a_hot_keeps_sticky: assert property (
    hot_rst && !wr |=> lnk_ctl_two == $past(lnk_ctl_two) ##1
      enter_compliance == $past(lnk_ctl_two[4], 2))
    else $error("sticky link control lost on hot reset");

  a_ido_gating: assert property (
    (!dev_ctl_two[8] |=> !ido_req_en) and
    (!dev_ctl_two[9] |=> !ido_cpl_en))
    else $error("ordering attribute enabled without its bit");

  a_deemph_low_rate: assert property (
    !link_5gt |=> !compliance_deemph)
    else $error("de-emphasis applied at low rate");

  a_compl_modes: assert property (
    wr && off == `PCX_OFF_LNK_CTL2 && cfg_be[1] |=> ##1
      mod_compliance == $past(cfg_wdata[10], 2) &&
      compliance_skp == $past(cfg_wdata[11], 2))
    else $error("compliance mode bits not followed");

  a_cto_report: assert property (
    cto_any |=> unc_flags[14] && cto_expired)
    else $error("timeout not reported");
endmodule : pcx_cfg_regs

// [bench/pcx_rc_model.sv]
module pcx_rc_model #(
  parameter int NTAG = 4
) (
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic [NTAG-1:0] req_issue,
  input  wire logic [7:0]      lag,
  output logic      [NTAG-1:0] cpl_done
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt [NTAG];

  // Answers each request after lag cycles; lag 0 means never
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cpl_done <= '0;
      foreach (cnt[g]) cnt[g] <= 0;
    end else begin
      for (int g = 0; g < NTAG; g++) begin
        cpl_done[g] <= (cnt[g] == 1);
        if (req_issue[g] && lag != 8'h00) cnt[g] <= int'(lag);
        else if (cnt[g] > 0) cnt[g] <= cnt[g] - 1;
      end
    end
  end
endmodule : pcx_rc_model

// [bench/tb_top.sv]
`include "pcx_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, nrst, hot_rst, cfg_req, cfg_wr, nvm_load, link_5gt;
  logic        sn_en, hint_en, lat_en, cur_deemph, cfg_ack, cfg_ur;
  logic        cto_expired, ido_req_en, ido_cpl_en, enter_comp, mod_comp;
  logic        comp_skp, comp_deemph;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, unc_set, cor_set, q, seed;
  logic [3:0]  cfg_be, nvm_ver, tgt_speed;
  logic [3:0]  req_issue, cpl_done;
  logic [7:0]  lag;
  logic [11:0] nxt;
  logic [31:0] keep;
  logic [127:0] hdr;
  int          err_total, n_compared, n;

  pcx_cfg_regs #(.NTAG(4), .TICK_CYC(1)) u_pcx_cfg_regs (
    .mclk(mclk), .nrst(nrst), .hot_rst(hot_rst), .cfg_req(cfg_req),
    .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .own_bus(8'h3c), .own_dev(5'h05), .own_fn(3'h2),
    .cfg_ack(cfg_ack), .cfg_ur(cfg_ur), .cfg_rdata(cfg_rdata),
    .nvm_load(nvm_load), .nvm_aer_ver(nvm_ver), .sn_cap_en(sn_en),
    .hint_cap_en(hint_en), .lat_cap_en(lat_en), .req_issue(req_issue),
    .cpl_done(cpl_done), .cto_expired(cto_expired), .link_5gt(link_5gt),
    .cur_deemph(cur_deemph), .unc_err_set(unc_set), .cor_err_set(cor_set),
    .err_hdr(hdr), .ido_req_en(ido_req_en),
    .ido_cpl_en(ido_cpl_en), .tgt_speed(tgt_speed),
    .enter_compliance(enter_comp), .mod_compliance(mod_comp),
    .compliance_skp(comp_skp), .compliance_deemph(comp_deemph));

  pcx_rc_model #(.NTAG(4)) u_pcx_rc_model (
    .mclk(mclk), .nrst(nrst), .req_issue(req_issue), .lag(lag),
    .cpl_done(cpl_done));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic wr, input logic [11:0] off,
                     input logic [31:0] d, input logic bad);
    @(posedge mclk);
    #1;
    cfg_req   = 1'b1;
    cfg_wr    = wr;
    cfg_wdata = d;
    cfg_addr  = {4'h0, 8'h3c, 5'h05, 3'h2, off[11:2], 2'b00};
    if (bad) cfg_addr[29] = 1'b1;
    @(posedge mclk);
    #1;
    cfg_req = 1'b0;
    chk({30'h0, cfg_ack, cfg_ur}, {30'h0, 1'b1, bad});
    q = cfg_rdata;
  endtask : cfg

  task automatic rd(input logic [11:0] off, input logic [31:0] exp);
    cfg(1'b0, off, 32'h0, 1'b0);
    chk(q, exp);
  endtask : rd

  task automatic tmo(input int g);
    @(posedge mclk);
    #1 req_issue[g] = 1'b1;
    @(posedge mclk);
    #1 req_issue = 4'h0;
    n = 0;
    while (cto_expired !== 1'b1 && n < 120) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : tmo

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up();
  end

  initial begin
    {nrst, hot_rst, cfg_req, cfg_wr, nvm_load, link_5gt} = '0;
    {sn_en, hint_en, lat_en, cur_deemph} = 4'hf;
    {cfg_addr, cfg_wdata, unc_set, cor_set, hdr} = '0;
    {cfg_be, nvm_ver, req_issue, lag} = {4'hf, 4'h0, 4'h0, 8'h00};
    {err_total, n_compared, seed} = {32'd0, 32'd0, 32'h42};
    repeat (10) @(posedge mclk);
    #1 nrst = 1'b1;
    rd(`PCX_OFF_DEV_CTL2, 32'h0);
    rd(`PCX_OFF_LNK_CTL2, 32'h1);
    for (int i = 0; i < 8; i++) begin
      {lat_en, hint_en, sn_en} = i[2:0];
      nxt = sn_en ? 12'h140 : hint_en ? 12'h1a0 : lat_en ? 12'h1c0 : 12'h0;
      rd(`PCX_OFF_AER_HDR, {nxt, 4'h2, 16'h0001});
    end
    cfg(1'b1, `PCX_OFF_AER_HDR, 32'hffffffff, 1'b0);
    rd(`PCX_OFF_AER_HDR, {12'h140, 4'h2, 16'h0001});
    @(posedge mclk);
    #1 {nvm_load, nvm_ver} = 5'h13;
    @(posedge mclk);
    #1 nvm_load = 1'b0;
    rd(`PCX_OFF_AER_HDR, {12'h140, 4'h3, 16'h0001});
    repeat (4) begin
      cfg_wdata = xs();
      cfg(1'b1, `PCX_OFF_DEV_CTL2, cfg_wdata, 1'b0);
      rd(`PCX_OFF_DEV_CTL2, cfg_wdata & 32'h031f);
    end
    keep = q;
    cfg(1'b1, `PCX_OFF_DEV_CTL2, 32'h0300, 1'b1);
    rd(`PCX_OFF_DEV_CTL2, keep);
    cfg(1'b1, `PCX_OFF_DEV_CTL2, 32'h0100, 1'b0);
    @(posedge mclk);
    #1 chk({ido_cpl_en, ido_req_en}, 2'b01);
    cfg(1'b1, `PCX_OFF_DEV_CTL2, 32'h0200, 1'b0);
    @(posedge mclk);
    #1 chk({ido_cpl_en, ido_req_en}, 2'b10);
    cfg(1'b1, `PCX_OFF_LNK_CTL2, 32'hffffffff, 1'b0);
    link_5gt = 1'b1;
    rd(`PCX_OFF_LNK_CTL2, 32'h00011f9f);
    chk({tgt_speed, enter_comp, mod_comp, comp_skp, comp_deemph},
        8'hff);
    link_5gt = 1'b0;
    rd(`PCX_OFF_LNK_CTL2, 32'h00001f9f);
    chk(comp_deemph, 1'b0);
    hdr = {xs(), xs(), xs(), xs()};
    unc_set = 32'hffffffff;
    cor_set = 32'hffffffff;
    @(posedge mclk);
    #1 {unc_set, cor_set} = '0;
    rd(`PCX_OFF_UNC_STAT, `PCX_UNC_IMPL);
    rd(`PCX_OFF_COR_STAT, `PCX_COR_IMPL);
    for (int i = 0; i < 4; i++) begin
      rd(12'(`PCX_OFF_HLOG0 + 4 * i), hdr[32 * i +: 32]);
    end
    cfg(1'b1, `PCX_OFF_UNC_STAT, 32'h0, 1'b0);
    rd(`PCX_OFF_UNC_STAT, `PCX_UNC_IMPL);
    cfg(1'b1, `PCX_OFF_UNC_STAT, 32'hffffffff, 1'b0);
    rd(`PCX_OFF_UNC_STAT, 32'h0);
    cfg(1'b1, `PCX_OFF_DEV_CTL2, 32'h0001, 1'b0);
    tmo(0);
    chk(n >= 49 && n <= 53, 1'b1);
    rd(`PCX_OFF_UNC_STAT, 32'h4000);
    lag = 8'd100;
    cfg(1'b1, `PCX_OFF_DEV_CTL2, 32'h0011, 1'b0);
    tmo(1);
    chk(n, 120);
    lag = 8'd20;
    cfg(1'b1, `PCX_OFF_DEV_CTL2, 32'h0001, 1'b0);
    tmo(2);
    chk(n, 120);
    @(posedge mclk);
    #1 hot_rst = 1'b1;
    @(posedge mclk);
    #1 hot_rst = 1'b0;
    rd(`PCX_OFF_DEV_CTL2, 32'h0);
    rd(`PCX_OFF_LNK_CTL2, 32'h1f9f);
    #3 nrst = 1'b0;
    @(posedge mclk);
    #1 nrst = 1'b1;
    rd(`PCX_OFF_LNK_CTL2, 32'h1);
    wrap_up();
  end
endmodule : tb_top
